// ### logic/sra_consts.svh
`ifndef SRA_CONSTS_SVH
`define SRA_CONSTS_SVH

// Frame layout
`define SRA_ADDR_W 15
`define SRA_DATA_W 8
`define SRA_HDR_LAST 4'hf
`define SRA_BYTE_LAST 3'h7

// Byte offsets of the register map
`define SRA_A_IF_CFG 15'h0000
`define SRA_A_DEV_SETUP 15'h0002
`define SRA_A_PART_CAT 15'h0003
`define SRA_A_PART_ID 15'h0004
`define SRA_A_MAKER_LO 15'h000c
`define SRA_A_MAKER_HI 15'h000d
`define SRA_A_USER_SETUP 15'h0010
`define SRA_A_CLK0 15'h0029
`define SRA_A_CLK1 15'h002a
`define SRA_A_CLK2 15'h002b
`define SRA_A_SYSREF_WIN 15'h002c
`define SRA_A_FS_A_LO 15'h0030
`define SRA_A_FS_A_HI 15'h0031
`define SRA_A_FS_B_LO 15'h0032
`define SRA_A_FS_B_HI 15'h0033
`define SRA_A_REF_BYP 15'h0038
`define SRA_A_TSTAMP 15'h003b
`define SRA_A_SER_EMPH 15'h0048
`define SRA_A_IN_SEL 15'h0060
`define SRA_A_CAL_EN 15'h0061
`define SRA_A_CAL_S0 15'h0062
`define SRA_A_CAL_S2 15'h0064
`define SRA_A_CALIB_AVERAGING 15'h0068
`define SRA_A_CAL_STATE 15'h006a
`define SRA_A_CAL_PIN 15'h006b
`define SRA_A_CAL_TRIG 15'h006c
`define SRA_A_CALIB_LOW_POWER 15'h006e
`define SRA_A_CAL_RD_EN 15'h0070
`define SRA_A_CAL_RD_VAL 15'h0071
`define SRA_A_GAIN_A 15'h007a
`define SRA_A_GAIN_B 15'h007b
`define SRA_A_BG_ADJ 15'h007c
`define SRA_A_TERM_A 15'h007e
`define SRA_A_TERM_B 15'h007f
`define SRA_A_DITHER 15'h009d
`define SRA_A_LOW_BIT 15'h0160
`define SRA_A_LINK_EN 15'h0200
`define SRA_A_LINK_MODE 15'h0201
`define SRA_A_MF_LEN 15'h0202
`define SRA_A_SYNC_REQ 15'h0203
`define SRA_A_LINK_CTRL 15'h0204
`define SRA_A_LINK_TEST 15'h0205
`define SRA_A_LINK_DEV 15'h0206

// Non-zero reset values, plus the zero default
`define SRA_R_IF_CFG 8'h30
`define SRA_R_CLK2 8'h11
`define SRA_R_FS_HI 8'ha0
`define SRA_R_ONE 8'h01
`define SRA_R_CAL_S2 8'h02
`define SRA_R_CALIB_AVERAGING 8'h61
`define SRA_R_CALIB_LOW_POWER 8'h88
`define SRA_R_LINK_MODE 8'h02
`define SRA_R_MF_LEN 8'h1f
`define SRA_R_LINK_CTRL 8'h03
`define SRA_R_ZERO 8'h00

// Field positions
`define SRA_ASC_HI_BIT 5
`define SRA_ASC_LO_BIT 2
`define SRA_HOLD_BIT 0

// Arbitrary neutral identity values
`define SRA_PART_CAT_VAL 8'h5a
`define SRA_PART_ID_VAL 8'h3c
`define SRA_MAKER_ID_VAL 16'h1234

`endif

// ### logic/sra_pkg.sv
package sra_pkg;

  typedef enum logic [1:0] {
    PH_HEAD = 2'b01,
    PH_DATA = 2'b10
  } frame_phase_t;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } wr_req_t;

  typedef struct packed {
    logic ascend;
    logic hold;
  } step_cfg_t;

endpackage

// ### logic/bit_sync.sv
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1_r <= RST;
      stage2_r <= RST;
    end else begin
      stage1_r <= i_d;
      stage2_r <= stage1_r;
    end
  end

  assign o_q = stage2_r;

endmodule

// ### logic/serial_register_access_port.sv
// Contract
// - Serial input is sampled on every rising serial clock edge.
// - Slow serial clock rates work, down to a stopped clock; the first read byte must reach rdata_r within half a clock.
// - A single access is one 24-bit frame: direction, address, data byte.
// - Every frame field travels most significant bit first.
// - Multi-byte registers are little-endian, low byte at lowest address.
// - First frame bit: one means read, zero means write.
// - The next fifteen bits carry the register address.
// - Write frame: last eight input bits are stored in the addressed register.
// - Read frame: last eight input bits ignored, register driven on output.
// - Output stays high impedance in writes and during read header bits.
// - Select held low after 24 bits keeps streaming bytes, same direction.
// - Streaming steps the address once per further byte, increment by default.
// - Address-direction bits in register zero choose increment or decrement.
// - Address-hold setting in the user serial setup stops address stepping.
`include "sra_consts.svh"

module serial_register_access_port
  import sra_pkg::*;
#(
  parameter int NREG = 43,
  parameter logic [7:0] PART_CAT = `SRA_PART_CAT_VAL,
  parameter logic [7:0] PART_ID = `SRA_PART_ID_VAL,
  parameter logic [15:0] MAKER_ID = `SRA_MAKER_ID_VAL
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_port_select_n,
  input wire logic i_shift_in,
  output logic o_shift_out,
  output logic o_shift_out_oe_n,
  input wire logic [7:0] i_sysref_window,
  input wire logic [7:0] i_calib_state,
  output logic [NREG*8-1:0] o_reg_image
);

  //////////////////////////////////////////////////////////////////////////////
  // Register map tables

  localparam logic [14:0] REG_ADDR [NREG] = '{
    `SRA_A_IF_CFG, `SRA_A_DEV_SETUP, `SRA_A_PART_CAT, `SRA_A_PART_ID,
    `SRA_A_MAKER_LO, `SRA_A_MAKER_HI, `SRA_A_USER_SETUP, `SRA_A_CLK0,
    `SRA_A_CLK1, `SRA_A_CLK2, `SRA_A_SYSREF_WIN, `SRA_A_FS_A_LO,
    `SRA_A_FS_A_HI, `SRA_A_FS_B_LO, `SRA_A_FS_B_HI, `SRA_A_REF_BYP,
    `SRA_A_TSTAMP, `SRA_A_SER_EMPH, `SRA_A_IN_SEL, `SRA_A_CAL_EN,
    `SRA_A_CAL_S0, `SRA_A_CAL_S2, `SRA_A_CALIB_AVERAGING, `SRA_A_CAL_STATE,
    `SRA_A_CAL_PIN, `SRA_A_CAL_TRIG, `SRA_A_CALIB_LOW_POWER, `SRA_A_CAL_RD_EN,
    `SRA_A_CAL_RD_VAL, `SRA_A_GAIN_A, `SRA_A_GAIN_B, `SRA_A_BG_ADJ,
    `SRA_A_TERM_A, `SRA_A_TERM_B, `SRA_A_DITHER, `SRA_A_LOW_BIT,
    `SRA_A_LINK_EN, `SRA_A_LINK_MODE, `SRA_A_MF_LEN, `SRA_A_SYNC_REQ,
    `SRA_A_LINK_CTRL, `SRA_A_LINK_TEST, `SRA_A_LINK_DEV
  };

  // Wide registers split low byte first, so 0xa000 resets as 00 then a0
  localparam logic [7:0] REG_RST [NREG] = '{
    `SRA_R_IF_CFG,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_CLK2,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_FS_HI,
    `SRA_R_ZERO,
    `SRA_R_FS_HI,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ONE,
    `SRA_R_ONE,
    `SRA_R_ONE,
    `SRA_R_CAL_S2,
    `SRA_R_CALIB_AVERAGING,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ONE,
    `SRA_R_CALIB_LOW_POWER,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ZERO,
    `SRA_R_ONE,
    `SRA_R_LINK_MODE,
    `SRA_R_MF_LEN,
    `SRA_R_ONE,
    `SRA_R_LINK_CTRL,
    `SRA_R_ZERO,
    `SRA_R_ZERO
  };

  localparam int IDX_IF_CFG = 0;
  localparam int IDX_USER = 6;

  //////////////////////////////////////////////////////////////////////////////
  // Link side: frame decode on the serial clock

  frame_phase_t phase_r;
  logic [3:0] hdr_cnt_r;
  logic dir_read_r;
  logic [13:0] addr_sh_r;
  logic [14:0] cur_addr_r;
  logic [2:0] bit_idx_r;
  logic [6:0] din_sh_r;
  logic wr_tgl_r;
  logic rd_tgl_r;
  wr_req_t wr_req_r;
  logic [14:0] rd_addr_r;
  logic [7:0] so_sh_r;
  logic so_en_r;
  step_cfg_t step_cfg_link;
  logic hdr_done;
  logic byte_done;
  logic byte_start;
  logic [14:0] full_addr;
  logic [14:0] next_addr;

  // Sys side signals read by the link side
  logic [7:0] rdata_r;
  step_cfg_t step_cfg_sys;

  assign hdr_done = (phase_r == PH_HEAD) && (hdr_cnt_r == `SRA_HDR_LAST);
  assign byte_done = (phase_r == PH_DATA) && (bit_idx_r == `SRA_BYTE_LAST);
  assign byte_start = (phase_r == PH_DATA) && (bit_idx_r == 3'h0);
  assign full_addr = {addr_sh_r, i_shift_in};

  always_comb begin
    if (step_cfg_link.hold) begin
      next_addr = cur_addr_r;
    end else if (step_cfg_link.ascend) begin
      next_addr = cur_addr_r + 15'h0001;
    end else begin
      next_addr = cur_addr_r - 15'h0001;
    end
  end

  // Settles within two edges; only read from the first data byte onward
  bit_sync #(
    .W(2),
    .RST(2'b10)
  ) u_cfg_sync (
    .i_clk(i_sclk),
    .i_rst(1'b0),
    .i_d(step_cfg_sys),
    .o_q(step_cfg_link)
  );

  // Select high clears the frame at once, since the clock may be stopped
  always_ff @(posedge i_sclk or posedge i_port_select_n) begin
    if (i_port_select_n) begin
      phase_r <= PH_HEAD;
      hdr_cnt_r <= 4'h0;
      dir_read_r <= 1'b0;
      addr_sh_r <= 14'h0000;
      cur_addr_r <= 15'h0000;
      bit_idx_r <= 3'h0;
      din_sh_r <= 7'h00;
    end else begin
      unique case (phase_r)
        PH_HEAD: begin
          hdr_cnt_r <= hdr_cnt_r + 4'h1;
          if (hdr_cnt_r == 4'h0) begin
            dir_read_r <= i_shift_in;
          end else begin
            addr_sh_r <= {addr_sh_r[12:0], i_shift_in};
          end
          if (hdr_done) begin
            cur_addr_r <= full_addr;
            phase_r <= PH_DATA;
            bit_idx_r <= 3'h0;
          end
        end
        PH_DATA: begin
          din_sh_r <= {din_sh_r[5:0], i_shift_in};
          bit_idx_r <= bit_idx_r + 3'h1;
          if (byte_done) begin
            cur_addr_r <= next_addr;
          end
        end
      endcase
    end
  end

  // Toggles live across frames, so only the system reset clears them
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      rd_tgl_r <= 1'b0;
      rd_addr_r <= 15'h0000;
    end else if (!i_port_select_n && dir_read_r) begin
      if (hdr_done) begin
        rd_addr_r <= full_addr;
        rd_tgl_r <= ~rd_tgl_r;
      end else if (byte_start) begin
        // Prefetch the next byte a whole byte time ahead
        rd_addr_r <= next_addr;
        rd_tgl_r <= ~rd_tgl_r;
      end
    end
  end

  // Request word stays put for a whole byte time after its toggle moves
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      wr_tgl_r <= 1'b0;
      wr_req_r <= '0;
    end else if (!i_port_select_n && !dir_read_r && byte_done) begin
      wr_req_r.addr <= cur_addr_r;
      wr_req_r.data <= {din_sh_r, i_shift_in};
      wr_tgl_r <= ~wr_tgl_r;
    end
  end

  // rdata_r has only half a serial clock to settle for the first read byte, several clocks for later bytes
  always_ff @(negedge i_sclk or posedge i_port_select_n) begin
    if (i_port_select_n) begin
      so_sh_r <= 8'h00;
      so_en_r <= 1'b0;
    end else if (byte_start && dir_read_r) begin
      so_sh_r <= rdata_r;
      so_en_r <= 1'b1;
    end else begin
      so_sh_r <= {so_sh_r[6:0], 1'b0};
    end
  end

  assign o_shift_out = so_sh_r[7];
  assign o_shift_out_oe_n = ~so_en_r;

  //////////////////////////////////////////////////////////////////////////////
  // System side: register storage

  logic [1:0] req_sync;
  logic wr_seen_r;
  logic rd_seen_r;
  logic wr_evt;
  logic rd_evt;
  logic [7:0] reg_r [NREG];
  logic [7:0] rd_val;
  logic [7:0] wr_byte;
  logic [NREG-1:0] rd_hit;
  logic [7:0] rd_term [NREG];
  logic [7:0] rd_stored;

  bit_sync #(
    .W(2),
    .RST(2'b00)
  ) u_req_sync (
    .i_clk(i_clk_sys),
    .i_rst(i_reset),
    .i_d({wr_tgl_r, rd_tgl_r}),
    .o_q(req_sync)
  );

  assign wr_evt = req_sync[1] ^ wr_seen_r;
  assign rd_evt = req_sync[0] ^ rd_seen_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wr_seen_r <= 1'b0;
      rd_seen_r <= 1'b0;
    end else begin
      wr_seen_r <= req_sync[1];
      rd_seen_r <= req_sync[0];
    end
  end

  // Both direction bits follow whichever one software sets
  always_comb begin
    wr_byte = wr_req_r.data;
    if (wr_req_r.addr == `SRA_A_IF_CFG) begin
      wr_byte[`SRA_ASC_HI_BIT] = wr_req_r.data[`SRA_ASC_HI_BIT] | wr_req_r.data[`SRA_ASC_LO_BIT];
      wr_byte[`SRA_ASC_LO_BIT] = wr_req_r.data[`SRA_ASC_HI_BIT] | wr_req_r.data[`SRA_ASC_LO_BIT];
    end
  end

  // Read-only entries never take writes; unmapped writes are dropped
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    localparam logic [14:0] A = REG_ADDR[g];
    localparam bit RO = (A == `SRA_A_PART_CAT) || (A == `SRA_A_PART_ID) ||
                        (A == `SRA_A_MAKER_LO) || (A == `SRA_A_MAKER_HI) ||
                        (A == `SRA_A_SYSREF_WIN) || (A == `SRA_A_CAL_STATE);
    always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
        reg_r[g] <= REG_RST[g];
      end else if (wr_evt && !RO && (wr_req_r.addr == A)) begin
        reg_r[g] <= wr_byte;
      end
    end
    assign o_reg_image[g*8 +: 8] = reg_r[g];
    assign rd_hit[g] = (rd_addr_r == A);
    assign rd_term[g] = rd_hit[g] ? reg_r[g] : 8'h00;
  end

  // At most one entry matches, so an OR of the masked bytes selects it
  always_comb begin
    rd_stored = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      rd_stored = rd_stored | rd_term[i];
    end
  end

  // Identity and live status bytes read from parameters and inputs, not from their stored entries
  always_comb begin
    unique case (rd_addr_r)
      `SRA_A_PART_CAT: rd_val = PART_CAT;
      `SRA_A_PART_ID: rd_val = PART_ID;
      `SRA_A_MAKER_LO: rd_val = MAKER_ID[7:0];
      `SRA_A_MAKER_HI: rd_val = MAKER_ID[15:8];
      `SRA_A_SYSREF_WIN: rd_val = i_sysref_window;
      `SRA_A_CAL_STATE: rd_val = i_calib_state;
      default: rd_val = rd_stored;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_r <= 8'h00;
    end else if (rd_evt) begin
      rdata_r <= rd_val;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      step_cfg_sys <= '{ascend: 1'b1, hold: 1'b0};
    end else begin
      step_cfg_sys.ascend <= reg_r[IDX_IF_CFG][`SRA_ASC_HI_BIT];
      step_cfg_sys.hold <= reg_r[IDX_USER][`SRA_HOLD_BIT];
    end
  end

endmodule

// ### verification/sra_checker_assertions.sv
module sra_checker #(
  parameter int NREG = 43
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_port_select_n,
  input wire logic i_shift_in,
  input wire logic o_shift_out,
  input wire logic o_shift_out_oe_n,
  input wire logic [7:0] i_sysref_window,
  input wire logic [7:0] i_calib_state,
  input wire logic [NREG*8-1:0] o_reg_image
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] cnt_r;
  logic dir_r;
  logic done_r = 1'b0;
  logic [2:0] sync_r;
  logic [7:0] since_r;
  ////////////////////////////////////////////////////////////////
  // Rises seen since select fell
  always_ff @(posedge i_sclk or posedge i_port_select_n) begin
    if (i_port_select_n) begin
      cnt_r <= 10'h000;
      dir_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 10'h001;
      if (cnt_r == 10'h000) begin
        dir_r <= i_shift_in;
      end
    end
  end
  // Toggles at every completed byte
  always_ff @(posedge i_sclk) begin
    if (!i_port_select_n && cnt_r >= 10'h017 && cnt_r[2:0] == 3'h7) begin
      done_r <= ~done_r;
    end
  end
  // Saturating age of the last completed byte, sys side
  always_ff @(posedge i_clk_sys) begin
    sync_r <= {sync_r[1:0], done_r};
    if (i_reset) begin
      since_r <= 8'hff;
    end else if (sync_r[2] != sync_r[1]) begin
      since_r <= 8'h00;
    end else if (since_r != 8'hff) begin
      since_r <= since_r + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_select_high_quiet: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_port_select_n |-> o_shift_out_oe_n) else $error("output enabled while deselected");
  a_header_no_drive: assert property (@(posedge i_sclk) disable iff (i_port_select_n)
    (cnt_r < 10'h010 || !dir_r) |-> o_shift_out_oe_n) else $error("output driven in header or write");
  a_read_drives: assert property (@(posedge i_sclk) disable iff (i_port_select_n)
    (cnt_r >= 10'h010 && dir_r) |-> !o_shift_out_oe_n) else $error("read data not driven");
  a_bit_held_high: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_sclk && $past(i_sclk) && !i_port_select_n) |-> $stable(o_shift_out)) else $error("data moved while clock high");
  a_enable_on_low: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $fell(o_shift_out_oe_n) |-> !i_sclk) else $error("enable fell with clock high");
  a_idle_clock_quiet: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ($stable(i_sclk) && $stable(i_port_select_n)) |-> ($stable(o_shift_out) && $stable(o_shift_out_oe_n)))
    else $error("output moved with serial clock stopped");
  a_image_after_byte: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $changed(o_reg_image) |-> since_r <= 8'h0a) else $error("register changed without a full byte");
  a_reset_ascends: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $fell(i_reset) |-> (o_reg_image[7:0] == 8'h30 && o_reg_image[55:48] == 8'h00)) else $error("bad reset setup");
endmodule

bind serial_register_access_port sra_checker #(.NREG(NREG)) chk_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_sclk(i_sclk), .i_port_select_n(i_port_select_n), .i_shift_in(i_shift_in), .o_shift_out(o_shift_out),
  .o_shift_out_oe_n(o_shift_out_oe_n), .i_sysref_window(i_sysref_window), .i_calib_state(i_calib_state),
  .o_reg_image(o_reg_image));

// ### verification/host_model.sv
module host_model (
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_mosi,
  input wire logic i_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock idles low between frames
  // Select dips once at start so the frame logic sees a real rising edge
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b0;
    o_mosi = 1'b0;
    #1;
    o_sel_n = 1'b1;
  end
  // Only listed registers are written, never during calibration
  task automatic frame(input logic rd, input logic [14:0] a, input logic [31:0] wd, input int nbits,
    input int half, output logic [31:0] q);
    logic [47:0] sh;
    sh = {rd, a, wd};
    q = '0;
    o_sel_n = 1'b0;
    #half;
    for (int i = 0; i < nbits; i++) begin
      o_mosi = sh[47-i];
      #half;
      o_sclk = 1'b1;
      q = {q[30:0], i_miso};
      #half;
      o_sclk = 1'b0;
    end
    #half;
    o_sel_n = 1'b1;
    // Released line must not keep its last value
    o_mosi = ~o_mosi;
  endtask
endmodule

// ### verification/testbench.sv
`include "sra_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b0;
  logic sclk, sel_n, mosi, shift_out, sdo_oe_n;
  wire logic line;
  logic [43*8-1:0] image;
  logic [31:0] q;
  int err_total = 0;
  int total_checks = 0;
  assign line = sdo_oe_n ? 1'bz : shift_out;
  serial_register_access_port DUT (.i_clk_sys(clk_sys), .i_reset(reset), .i_sclk(sclk), .i_port_select_n(sel_n),
    .i_shift_in(mosi), .o_shift_out(shift_out), .o_shift_out_oe_n(sdo_oe_n), .i_sysref_window(8'h6b),
    .i_calib_state(8'h96), .o_reg_image(image));
  host_model host (.o_sclk(sclk), .o_sel_n(sel_n), .o_mosi(mosi), .i_miso(line));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic r, input logic [14:0] a, input logic [31:0] d, input int nb, input int half = 40);
    @(posedge clk_sys);
    #1;
    host.frame(r, a, d, nb, half, q);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic reset_values;
    logic [14:0] ra [11] = '{15'h0000, 15'h002b, 15'h0031, 15'h0002, 15'h002c, 15'h006a, 15'h0001,
      15'h0200, 15'h0202, 15'h006e, 15'h0003};
    logic [7:0] rv [11] = '{8'h30, 8'h11, 8'ha0, 8'h00, 8'h6b, 8'h96, 8'h00, 8'h01, 8'h1f, 8'h88,
      `SRA_PART_CAT_VAL};
    foreach (ra[i]) begin
      xfer(1'b1, ra[i], 32'hff000000, 24);
      chk("reset_read", rv[i], q[7:0]);
    end
    xfer(1'b1, 15'h000c, 32'h0, 32);
    chk("maker_lo", 8'(`SRA_MAKER_ID_VAL), q[15:8]);
    chk("maker_hi", 8'(`SRA_MAKER_ID_VAL >> 8), q[7:0]);
  endtask
  task automatic single_write;
    xfer(1'b0, 15'h0029, 32'ha5000000, 24);
    chk("clk0_img", 8'ha5, image[7*8+:8]);
    xfer(1'b1, 15'h0029, 32'h5a000000, 24);
    chk("clk0_read", 8'ha5, q[7:0]);
    xfer(1'b0, 15'h0003, 32'hee000000, 24);
    xfer(1'b1, 15'h0003, 32'h0, 24);
    chk("ro_read", `SRA_PART_CAT_VAL, q[7:0]);
  endtask
  task automatic stream_up;
    xfer(1'b0, 15'h0029, 32'h11223300, 44);
    chk("up0", 8'h11, image[7*8+:8]);
    chk("up1", 8'h22, image[8*8+:8]);
    chk("up2", 8'h33, image[9*8+:8]);
    xfer(1'b1, 15'h0029, 32'h0, 40);
    chk("up_read", 8'h11, q[23:16]);
    chk("up_read", 8'h33, q[7:0]);
  endtask
  task automatic stream_down;
    xfer(1'b0, 15'h0000, 32'h0, 24);
    xfer(1'b0, 15'h002b, 32'h44550000, 32);
    chk("dn0", 8'h44, image[9*8+:8]);
    chk("dn1", 8'h55, image[8*8+:8]);
    xfer(1'b0, 15'h0000, 32'h04000000, 24);
    chk("cfg0", 8'h24, image[7:0]);
  endtask
  task automatic hold_addr;
    xfer(1'b0, 15'h0010, 32'h01000000, 24);
    xfer(1'b0, 15'h0029, 32'h66770000, 32);
    chk("hold0", 8'h77, image[7*8+:8]);
    chk("hold1", 8'h55, image[8*8+:8]);
    xfer(1'b0, 15'h0010, 32'h0, 24);
  endtask
  task automatic abort_frame;
    xfer(1'b0, 15'h0029, 32'h99000000, 20);
    chk("abort", 8'h77, image[7*8+:8]);
    // Slow clock right after the abort
    xfer(1'b0, 15'h002a, 32'h3c000000, 24, 400);
    chk("after_abort", 8'h3c, image[8*8+:8]);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    // A declared start value makes no edge; the link toggles clear only on one
    #1;
    reset = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_values;
    single_write;
    stream_up;
    stream_down;
    hold_addr;
    abort_frame;
    give_verdict;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    give_verdict;
  end
endmodule
